/* File: core/ebx_bus.sv */
// External memory bus logic with eight selectable data pointers
// Summary of operation
// R1: Write byte on mux port before store strobe, held past its release; code drives it from the strobe's first cycle, not before.
// R2: Memory drives read byte; device samples it before read strobe ends.
// R3: Code fetches strobe with code_fetch_strobe_n only.
// R4: Force pin low sends every fetch to external memory.
// R5: Fetches above 01FFFH always go external.
// R6: External execution gives all high port lines to address.
// R7: Address output never changes the high port latch.
// R8: Code fetch puts program counter high byte on high port.
// R9: Data access: pointer high byte for 16-bit, latch for 8-bit move.
// R10: Romless variant: every fetch external, high port always address.
// R11: Romless variant: neither port available as general I/O.
// R12: Eight independent 16-bit pointer registers.
// R13: Exactly one pointer is active at any time.
// R14: Three-bit field of pointer_select picks the active pointer.
// R15: Pointer reads, writes, increments use only the selected one.
// R16: Active pointer seen as high and low byte registers.
// R17: One pointer_select write switches the active pointer.
// R18: pointer_select lives at special function address 92H.
// R19: Mux port actively drives address then data, not open drain.
// R20: Every external access writes FF into the mux port latch.
// R21: Unselected pointers keep their contents.
`timescale 1ns/1ps
`default_nettype none
module ebx_bus #(
  parameter bit ROMLESS = 1'b0,
  parameter int NUM_PTR = ebx_pkg::EBX_NUM_PTR
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Core special function register access
  input wire logic I_SFR_WR,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  input wire logic I_PTR_INC,
  // Port latches from the core
  input wire logic [7:0] I_MUX_LATCH,
  input wire logic [7:0] I_HIGH_LATCH,
  output logic O_MUX_LATCH_SET,
  // Access requests from the core
  input wire logic I_FETCH_REQ,
  input wire logic [15:0] I_PC,
  input wire logic I_DATA_REQ,
  input wire logic I_DATA_WRITE,
  input wire logic I_DATA_WIDE,
  input wire logic [7:0] I_DATA_LOW_ADDR,
  input wire logic [7:0] I_DATA_WDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_FETCH_EXT,
  output logic [7:0] O_RDATA,
  // Fetch routing pin
  input wire logic I_OFFCHIP_FETCH_FORCE_N,
  // External bus pins
  input wire logic [7:0] I_MUX_BUS_PORT,
  output logic [7:0] O_MUX_BUS_PORT,
  output logic O_MUX_BUS_PORT_OE,
  output logic [7:0] O_HIGH_ADDR_PORT,
  output logic O_HIGH_ADDR_BUS,
  output logic O_MUX_BUS_OWNED,
  output logic O_ADDR_LATCH_EN,
  output logic O_CODE_FETCH_STROBE_N,
  output logic O_DATA_FETCH_STROBE_N,
  output logic O_DATA_STORE_STROBE_N
);
  import ebx_pkg::*;

  ebx_state_t state_reg, state_next;
  logic [EBX_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] sel_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg, rdata_reg;
  logic ext_exec_reg;
  logic [15:0] active_ptr;
  logic [7:0] mux_port_reg;
  logic [7:0] high_port_reg;
  logic [7:0] sfr_rdata_reg;

  // R14: three-bit select field
  wire [EBX_SEL_W-1:0] sel_field = sel_reg[EBX_SEL_W-1:0];
  // R18: select register address
  wire sel_wr = I_SFR_WR && (I_SFR_ADDR == EBX_SFR_SEL_ADDR);
  // R16: byte registers of active pointer
  wire lo_wr = I_SFR_WR && (I_SFR_ADDR == EBX_SFR_PTRL_ADDR);
  wire hi_wr = I_SFR_WR && (I_SFR_ADDR == EBX_SFR_PTRH_ADDR);

  // R4: force pin routes fetch
  // R5: above internal range
  // R10: romless always external
  wire fetch_ext = ROMLESS || !I_OFFCHIP_FETCH_FORCE_N || (I_PC > EBX_INT_ROM_TOP);
  wire idle = (state_reg == EBX_IDLE);
  wire start_code = idle && I_FETCH_REQ && fetch_ext;
  wire start_data = idle && !start_code && I_DATA_REQ;
  // R9: high byte source for data
  wire [7:0] data_hi = I_DATA_WIDE ? active_ptr[15:8] : I_HIGH_LATCH;
  wire [7:0] data_lo = I_DATA_WIDE ? active_ptr[7:0] : I_DATA_LOW_ADDR;
  wire [EBX_CNT_W-1:0] last_cnt =
    (state_reg == EBX_CODE) ? EBX_CNT_W'(EBX_CODE_CYC) : EBX_CNT_W'(EBX_DATA_CYC);
  wire in_xfer = (state_reg == EBX_CODE) || (state_reg == EBX_RDAT) ||
                 (state_reg == EBX_WDAT);
  wire addr_phase = in_xfer && (cnt_reg == EBX_ALE_END);
  wire strobe_phase = in_xfer && (cnt_reg >= EBX_STB_START) && (cnt_reg < last_cnt);
  // R3: one strobe per kind of access
  wire code_strobe = strobe_phase && (state_reg == EBX_CODE);
  wire read_strobe = strobe_phase && (state_reg == EBX_RDAT);
  wire store_strobe = strobe_phase && (state_reg == EBX_WDAT);

  // Port values are registered from the next-cycle view, so they keep the strobes' timing
  wire next_xfer = (state_next == EBX_CODE) || (state_next == EBX_RDAT) ||
                   (state_next == EBX_WDAT);
  wire next_addr_phase = next_xfer && (cnt_next == EBX_ALE_END);
  wire [15:0] addr_next = start_code ? I_PC : start_data ? {data_hi, data_lo} : addr_reg;
  wire [7:0] wdata_next = start_data ? I_DATA_WDATA : wdata_reg;
  wire [7:0] mux_port_next = next_addr_phase ? addr_next[7:0] :
                             (state_next == EBX_WDAT) ? wdata_next : I_MUX_LATCH;
  wire [7:0] high_port_next = next_xfer ? addr_next[15:8] : I_HIGH_LATCH;
  // R16: byte registers read back through a flop
  wire [7:0] sfr_rdata_next = (I_SFR_ADDR == EBX_SFR_SEL_ADDR) ? sel_reg :
                              (I_SFR_ADDR == EBX_SFR_PTRL_ADDR) ? active_ptr[7:0] :
                              (I_SFR_ADDR == EBX_SFR_PTRH_ADDR) ? active_ptr[15:8] : 8'h00;

  // R12: eight pointer registers
  ebx_ptr_bank #(
    .NUM_PTR(NUM_PTR),
    .SEL_W(EBX_SEL_W)
  ) u_ptr_bank (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_sel(sel_field),
    .i_wr_lo(lo_wr),
    .i_wr_hi(hi_wr),
    .i_wdata(I_SFR_WDATA),
    .i_inc(I_PTR_INC),
    .o_active(active_ptr)
  );

  // R17: single write switches pointer
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sel_reg <= 8'h00;
    end else if (sel_wr) begin
      sel_reg <= I_SFR_WDATA & ((8'h01 << (EBX_SEL_FIELD_MSB + 8'h01)) - 8'h01);
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      EBX_IDLE: begin
        cnt_next = '0;
        if (start_code) begin
          state_next = EBX_CODE;
        end else if (start_data) begin
          state_next = I_DATA_WRITE ? EBX_WDAT : EBX_RDAT;
        end
      end
      EBX_CODE, EBX_RDAT, EBX_WDAT: begin
        if (cnt_reg == last_cnt) begin
          state_next = EBX_DONE;
        end else begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
      EBX_DONE: begin
        state_next = EBX_IDLE;
      end
      default: begin
        state_next = EBX_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= EBX_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Address captured at start, so a pointer change mid-cycle cannot glitch the bus
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (start_code) begin
      // R8: program counter high byte
      addr_reg <= I_PC;
    end else if (start_data) begin
      addr_reg <= {data_hi, data_lo};
      wdata_reg <= I_DATA_WDATA;
    end
  end

  // R2: sample before read strobe ends
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 8'h00;
    end else if ((code_strobe || read_strobe) && (cnt_reg == last_cnt - 3'h1)) begin
      rdata_reg <= I_MUX_BUS_PORT;
    end
  end

  // R6: external execution owns high port
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ext_exec_reg <= ROMLESS;
    end else if (start_code) begin
      ext_exec_reg <= 1'b1;
    end else if (idle && I_FETCH_REQ) begin
      ext_exec_reg <= ROMLESS;
    end
  end

  // R3: code strobe only for fetches
  assign O_CODE_FETCH_STROBE_N = !code_strobe;
  assign O_DATA_FETCH_STROBE_N = !read_strobe;
  assign O_DATA_STORE_STROBE_N = !store_strobe;
  assign O_ADDR_LATCH_EN = addr_phase;

  // R1: write data held past strobe
  // R19: actively driven, not open drain
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mux_port_reg <= EBX_PORT_RESET;
    end else begin
      mux_port_reg <= mux_port_next;
    end
  end
  assign O_MUX_BUS_PORT = mux_port_reg;
  assign O_MUX_BUS_PORT_OE = addr_phase || (state_reg == EBX_WDAT);
  // R11: romless or external execution keeps mux port as bus
  assign O_MUX_BUS_OWNED = ROMLESS || ext_exec_reg || in_xfer || (state_reg == EBX_DONE);

  // R7: latch value never written here
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      high_port_reg <= EBX_PORT_RESET;
    end else begin
      high_port_reg <= high_port_next;
    end
  end
  assign O_HIGH_ADDR_PORT = high_port_reg;
  assign O_HIGH_ADDR_BUS = ext_exec_reg || in_xfer;

  // R20: FF loaded into mux latch
  assign O_MUX_LATCH_SET = start_code || start_data;

  // Read data lags the address by one cycle, a flop in place of a wide mux on the pins
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sfr_rdata_reg <= 8'h00;
    end else begin
      sfr_rdata_reg <= sfr_rdata_next;
    end
  end
  assign O_SFR_RDATA = sfr_rdata_reg;
  assign O_BUSY = !idle;
  assign O_DONE = (state_reg == EBX_DONE);
  assign O_FETCH_EXT = fetch_ext;
  assign O_RDATA = rdata_reg;
endmodule
`default_nettype wire

/* File: core/ebx_pkg.sv */
// Package: constants for the external bus and multi-pointer block
package ebx_pkg;
  localparam int EBX_NUM_PTR = 8;
  localparam int EBX_SEL_W = 3;
  localparam logic [7:0] EBX_SFR_SEL_ADDR = 8'h92;
  localparam logic [7:0] EBX_SFR_PTRL_ADDR = 8'h82;
  localparam logic [7:0] EBX_SFR_PTRH_ADDR = 8'h83;
  localparam logic [15:0] EBX_INT_ROM_TOP = 16'h1fff;
  localparam logic [7:0] EBX_PORT_RESET = 8'hff;
  localparam logic [15:0] EBX_PTR_RESET = 16'h0000;
  localparam logic [7:0] EBX_SEL_FIELD_MSB = 8'h02;
  localparam int EBX_CODE_CYC = 3;
  localparam int EBX_DATA_CYC = 6;
  localparam int EBX_CNT_W = 3;
  localparam logic [2:0] EBX_ALE_END = 3'h0;
  localparam logic [2:0] EBX_STB_START = 3'h1;
  typedef enum logic [2:0] {
    EBX_IDLE = 3'b000,
    EBX_CODE = 3'b001,
    EBX_RDAT = 3'b010,
    EBX_WDAT = 3'b011,
    EBX_DONE = 3'b100
  } ebx_state_t;
endpackage

/* File: core/ebx_ptr_bank.sv */
// Bank of eight 16-bit data pointers with one selected as active
`timescale 1ns/1ps
`default_nettype none
module ebx_ptr_bank #(
  parameter int NUM_PTR = 8,
  parameter int SEL_W = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Selection
  input wire logic [SEL_W-1:0] i_sel,
  // Writes and increment on the active pointer
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  input wire logic i_inc,
  // Active pointer
  output logic [15:0] o_active
);
  import ebx_pkg::*;
  logic [15:0] ptr_reg [NUM_PTR];

  genvar g;
  generate
    for (g = 0; g < NUM_PTR; g++) begin : g_ptr
      wire hit = (i_sel == SEL_W'(g));
      wire [15:0] inc_val = ptr_reg[g] + 16'h0001;
      // R15: selected only acts
      // R21: others keep contents
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          ptr_reg[g] <= EBX_PTR_RESET;
        end else if (hit && i_inc) begin
          ptr_reg[g] <= inc_val;
        end else if (hit && i_wr_lo) begin
          ptr_reg[g][7:0] <= i_wdata;
        end else if (hit && i_wr_hi) begin
          ptr_reg[g][15:8] <= i_wdata;
        end
      end
    end
  endgenerate

  // R13: one active pointer
  assign o_active = ptr_reg[i_sel];
endmodule
`default_nettype wire

/* File: bench/ebx_bus_asserts.sv */
// Checker of the external bus strobes and ports
`timescale 1ns/1ps
`default_nettype none
module ebx_bus_chk (
  // Clock, reset and core side
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [15:0] I_PC,
  input wire logic I_OFFCHIP_FETCH_FORCE_N,
  input wire logic O_MUX_LATCH_SET,
  input wire logic O_DONE,
  input wire logic O_FETCH_EXT,
  // Bus pins
  input wire logic [7:0] O_MUX_BUS_PORT,
  input wire logic O_MUX_BUS_PORT_OE,
  input wire logic [7:0] O_HIGH_ADDR_PORT,
  input wire logic O_HIGH_ADDR_BUS,
  input wire logic O_ADDR_LATCH_EN,
  input wire logic O_CODE_FETCH_STROBE_N,
  input wire logic O_DATA_FETCH_STROBE_N,
  input wire logic O_DATA_STORE_STROBE_N,
  input wire logic O_MUX_BUS_OWNED
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_store_data_held: assert property ($rose(O_DATA_STORE_STROBE_N) |->
    O_MUX_BUS_PORT_OE && $stable(O_MUX_BUS_PORT)) else $error("store data dropped");
  a_read_bus_free: assert property (!O_DATA_FETCH_STROBE_N |-> !O_MUX_BUS_PORT_OE)
    else $error("bus driven in read");
  a_code_strobe_only: assert property (!O_CODE_FETCH_STROBE_N |->
    O_DATA_FETCH_STROBE_N && O_DATA_STORE_STROBE_N) else $error("strobes mixed");
  a_code_end_done: assert property ($rose(O_CODE_FETCH_STROBE_N) |=> O_DONE)
    else $error("no done after fetch");
  a_force_fetch_ext: assert property (!I_OFFCHIP_FETCH_FORCE_N |-> O_FETCH_EXT)
    else $error("forced fetch internal");
  a_high_pc_ext: assert property (I_PC > 16'h1fff |-> O_FETCH_EXT)
    else $error("high pc internal");
  a_fetch_pc_high: assert property (!O_CODE_FETCH_STROBE_N |-> O_HIGH_ADDR_BUS &&
    O_HIGH_ADDR_PORT == I_PC[15:8]) else $error("fetch address wrong");
  a_latch_then_ale: assert property (O_MUX_LATCH_SET |=> O_ADDR_LATCH_EN)
    else $error("no address strobe");
  a_addr_driven: assert property (O_ADDR_LATCH_EN |-> O_MUX_BUS_PORT_OE)
    else $error("address not driven");
  a_mux_owned: assert property (O_ADDR_LATCH_EN || !O_DATA_FETCH_STROBE_N |->
    O_MUX_BUS_OWNED) else $error("mux port not owned");
  c_code: cover property ($fell(O_CODE_FETCH_STROBE_N));
  c_read: cover property ($fell(O_DATA_FETCH_STROBE_N));
  c_write: cover property ($fell(O_DATA_STORE_STROBE_N));
endmodule
bind ebx_bus ebx_bus_chk u_chk (.*);
`default_nettype wire

/* File: bench/ebx_mem_model.sv */
// Behavioural external program and data memory
`timescale 1ns/1ps
`default_nettype none
module ebx_mem_model (
  // Bus from the block
  input wire logic clk,
  input wire logic ale,
  input wire logic oe,
  input wire logic code_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] mux_out,
  input wire logic [7:0] high,
  // Back to the block
  output logic [7:0] mux_in,
  output logic [7:0] wbyte
);
  logic [15:0] addr = 16'h0000;
  logic [7:0] last = 8'h00;
  always @(posedge clk) begin
    if (ale) addr <= {high, mux_out};
    if (!wr_n) wbyte <= mux_out;
    last <= mux_in;
  end
  // drive read byte; a released bus shows changing junk so stale data cannot pass
  always_comb begin
    if (oe) mux_in = mux_out;
    else if (!code_n || !rd_n) mux_in = addr[7:0] ^ addr[15:8] ^ 8'h5a;
    else mux_in = ~last;
  end
endmodule
`default_nettype wire

/* File: bench/external_bus_multi_pointer_bench.sv */
// Self-checking bench of the external bus block
`timescale 1ns/1ps
`default_nettype none
module external_bus_multi_pointer_bench;
  import ebx_pkg::*;
  logic I_CLK = 1'b0, I_RST = 1'b1, I_SFR_WR = 1'b0, I_PTR_INC = 1'b0, I_FETCH_REQ = 1'b0;
  logic I_DATA_REQ = 1'b0, I_DATA_WRITE = 1'b0, I_DATA_WIDE = 1'b0;
  logic I_OFFCHIP_FETCH_FORCE_N = 1'b1;
  logic [7:0] I_SFR_ADDR = 8'h00, I_SFR_WDATA = 8'h00, I_MUX_LATCH = 8'hff;
  logic [7:0] I_HIGH_LATCH = 8'h00, I_DATA_LOW_ADDR = 8'h00, I_DATA_WDATA = 8'h00;
  logic [15:0] I_PC = 16'h0000;
  logic [15:0] ptr [8];
  logic [7:0] I_MUX_BUS_PORT, O_SFR_RDATA, O_RDATA, O_MUX_BUS_PORT, O_HIGH_ADDR_PORT, wbyte;
  logic O_MUX_LATCH_SET, O_BUSY, O_DONE, O_FETCH_EXT, O_MUX_BUS_PORT_OE, O_HIGH_ADDR_BUS;
  logic O_MUX_BUS_OWNED, O_ADDR_LATCH_EN, O_CODE_FETCH_STROBE_N, O_DATA_FETCH_STROBE_N;
  logic O_DATA_STORE_STROBE_N;
  int mismatches = 0;
  int checks = 0;
  wire strb = !(O_CODE_FETCH_STROBE_N & O_DATA_FETCH_STROBE_N & O_DATA_STORE_STROBE_N);
  ebx_bus dut (.*);
  ebx_mem_model mem (.clk(I_CLK), .ale(O_ADDR_LATCH_EN), .oe(O_MUX_BUS_PORT_OE),
    .code_n(O_CODE_FETCH_STROBE_N), .rd_n(O_DATA_FETCH_STROBE_N), .wr_n(O_DATA_STORE_STROBE_N),
    .mux_out(O_MUX_BUS_PORT), .high(O_HIGH_ADDR_PORT), .mux_in(I_MUX_BUS_PORT), .wbyte(wbyte));
  initial forever #5 I_CLK = ~I_CLK;
  always @(posedge I_CLK) if (O_MUX_LATCH_SET) I_MUX_LATCH <= 8'hff;
  function automatic logic [7:0] mf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Tasks are entered just after a rising edge and leave at one
  task automatic sw(input logic [7:0] a, v);
    I_SFR_ADDR <= a;
    I_SFR_WDATA <= v;
    I_SFR_WR <= 1'b1;
    @(posedge I_CLK) I_SFR_WR <= 1'b0;
    @(posedge I_CLK);
  endtask
  task automatic sr(input string nm, input logic [7:0] a, e);
    I_SFR_ADDR <= a;
    @(posedge I_CLK);
    #1 chk(nm, O_SFR_RDATA, e);
    @(posedge I_CLK);
  endtask
  task automatic acc(input logic f, w, wd, input logic [7:0] la, v, output logic [7:0] h);
    I_FETCH_REQ <= f;
    I_DATA_REQ <= !f;
    I_DATA_WRITE <= w;
    I_DATA_WIDE <= wd;
    I_DATA_LOW_ADDR <= la;
    I_DATA_WDATA <= v;
    for (int n = 0; n < 20; n++) begin
      @(posedge I_CLK);
      I_FETCH_REQ <= 1'b0;
      I_DATA_REQ <= 1'b0;
      #1 if (strb) h = O_HIGH_ADDR_PORT;
      if (O_DONE === 1'b1) begin
        chk("latch", O_HIGH_ADDR_PORT, I_HIGH_LATCH);
        chk("own", O_HIGH_ADDR_BUS, f);
        @(posedge I_CLK);
        return;
      end
    end
    mismatches++;
    conclude();
  endtask
  initial begin
    logic [7:0] h, d, la;
    logic [15:0] a;
    int k;
    void'($urandom(32'h2f09));
    I_HIGH_LATCH <= 8'($urandom);
    repeat (20) @(posedge I_CLK);
    I_RST <= 1'b0;
    sr("sel", EBX_SFR_SEL_ADDR, 8'h00);
    for (k = 0; k < 8; k++) begin
      ptr[k] = 16'($urandom);
      sw(EBX_SFR_SEL_ADDR, 8'hf8 | 8'(k));
      sw(EBX_SFR_PTRL_ADDR, ptr[k][7:0]);
      sw(EBX_SFR_PTRH_ADDR, ptr[k][15:8]);
    end
    for (k = 7; k >= 0; k--) begin
      sw(EBX_SFR_SEL_ADDR, 8'(k));
      sr("sel", EBX_SFR_SEL_ADDR, 8'(k));
      sr("lo", EBX_SFR_PTRL_ADDR, ptr[k][7:0]);
      sr("hi", EBX_SFR_PTRH_ADDR, ptr[k][15:8]);
    end
    sw(EBX_SFR_PTRL_ADDR, 8'hff);
    I_PTR_INC <= 1'b1;
    @(posedge I_CLK) I_PTR_INC <= 1'b0;
    @(posedge I_CLK);
    sr("inc", EBX_SFR_PTRH_ADDR, 8'(ptr[0][15:8] + 8'h01));
    sr("inc", EBX_SFR_PTRL_ADDR, 8'h00);
    for (k = 1; k < 8; k++) begin
      sw(EBX_SFR_SEL_ADDR, 8'(k));
      la = 8'($urandom);
      d = 8'($urandom);
      a = k[1] ? ptr[k] : {I_HIGH_LATCH, la};
      acc(1'b0, k[0], k[1], la, d, h);
      chk("high", h, a[15:8]);
      if (k[0]) chk("wr", wbyte, d);
      else chk("rd", O_RDATA, mf(a));
    end
    I_PC <= 16'h1fff;
    I_FETCH_REQ <= 1'b1;
    repeat (2) @(posedge I_CLK);
    #1 chk("busy", O_BUSY, 1'b0);
    chk("ext", O_FETCH_EXT, 1'b0);
    @(posedge I_CLK);
    I_FETCH_REQ <= 1'b0;
    I_OFFCHIP_FETCH_FORCE_N <= 1'b0;
    @(posedge I_CLK);
    acc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, h);
    chk("pc", h, 8'h1f);
    chk("code", O_RDATA, mf(I_PC));
    I_OFFCHIP_FETCH_FORCE_N <= 1'b1;
    I_PC <= 16'($urandom) | 16'h2000;
    @(posedge I_CLK);
    acc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, h);
    chk("pc", h, I_PC[15:8]);
    chk("code", O_RDATA, mf(I_PC));
    conclude();
  end
endmodule
`default_nettype wire
